// File: bench/board_pins.sv
`timescale 1ns/100ps
// ==========================
// Board side of the pins
module board_pins (
  input wire [2:0] portZeroOut_q,
  input wire [2:0] portZeroOe_q,
  input wire [2:0] portZeroPullup_q,
  input wire [7:0] portFiveOut_q,
  input wire [7:0] portFiveOe_q,
  input wire [7:0] portFivePullup_q,
  input wire [7:0] portTwoOut_q,
  input wire [7:0] portTwoOe_q,
  input wire [1:0] portFourOut_q,
  input wire [1:0] portFourOe_q,
  input wire [2:0] ext0,
  input wire [7:0] ext5,
  input wire [7:0] ext2,
  output wire [2:0] portZeroIn,
  output wire [7:0] portFiveIn,
  output wire [7:0] portTwoIn,
  output wire [1:0] portFourIn
);
  // Released pins show the board level; a pull-up outweighs it
  assign portZeroIn = portZeroOe_q & portZeroOut_q
    | ~portZeroOe_q & (portZeroPullup_q | ext0);
  assign portFiveIn = portFiveOe_q & portFiveOut_q
    | ~portFiveOe_q & (portFivePullup_q | ext5);
  assign portTwoIn = portTwoOe_q & portTwoOut_q | ~portTwoOe_q & ext2;
  // Resistors to supply hold the debug pins high, also through reset
  assign portFourIn = portFourOe_q & portFourOut_q | ~portFourOe_q;
endmodule

// File: bench/port_pin_function_select_test.sv
`timescale 1ns/100ps
`include "port_select_map.vh"
// ==========================
// Port select bench
module port_pin_function_select_test;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00;
  logic regWrite = 1'b0, regRead = 1'b0, serialThreeTransmit = 1'b1;
  logic debugEnableOptionBit = 1'b1, debugActive = 1'b0;
  logic debugTwoLine = 1'b0, flashWriteMode = 1'b0;
  logic debugDataOut = 1'b0, debugDataOe = 1'b0, debugClockOut = 1'b0;
  // The top two port-two pins are high so that analog masking shows on reads
  logic [7:0] lcdSegmentOutput = 8'h3C, ext5 = 8'h00, ext2 = 8'hCC;
  logic [2:0] ext0 = 3'h2;
  wire [7:0] regRdata_q, portFiveIn, portFiveOut_q, portFiveOe_q;
  wire [7:0] portFivePullup_q, portTwoIn, portTwoOut_q, portTwoOe_q;
  wire [7:0] analogSelect_q;
  wire [2:0] portZeroIn, portZeroOut_q, portZeroOe_q, portZeroPullup_q;
  wire [1:0] portFourIn, portFourOut_q, portFourOe_q;
  wire lcdPinsOwned_q, serialThreeReceive_q, timerInputTwo_q;
  wire timerInputFour_q, debugDataIn_q, debugDataSampled_q;
  int miscompares = 0;
  int checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  port_pin_function_select DUT (.ref_clk, .reset_n, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata_q, .portZeroIn, .portZeroOut_q,
    .portZeroOe_q, .portZeroPullup_q, .lcdPinsOwned_q, .portFiveIn,
    .portFiveOut_q, .portFiveOe_q, .portFivePullup_q, .serialThreeTransmit,
    .serialThreeReceive_q, .timerInputTwo_q, .timerInputFour_q,
    .lcdSegmentOutput, .portTwoIn, .portTwoOut_q, .portTwoOe_q,
    .analogSelect_q, .debugEnableOptionBit, .debugActive, .debugTwoLine,
    .flashWriteMode, .debugDataOut, .debugDataOe, .debugClockOut,
    .portFourIn, .portFourOut_q, .portFourOe_q, .debugDataIn_q,
    .debugDataSampled_q);
  board_pins BRD (.portZeroOut_q, .portZeroOe_q, .portZeroPullup_q,
    .portFiveOut_q, .portFiveOe_q, .portFivePullup_q, .portTwoOut_q,
    .portTwoOe_q, .portFourOut_q, .portFourOe_q, .ext0, .ext5, .ext2,
    .portZeroIn, .portFiveIn, .portTwoIn, .portFourIn);
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    cmp(regRdata_q, exp);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic s_reset;
    step(1);
    cmp(portTwoOe_q | analogSelect_q, 8'h00);
    cmp(8'(debugDataSampled_q), 8'h01);
    rd(`ADDR_P2_DIR, 8'hFF);
    rd(`ADDR_ADCFG, 8'h08);
    rd(`ADDR_LCDMODE, 8'h00);
    rd(8'h20, 8'h00);
  endtask
  task automatic s_port0;
    wr(`ADDR_P0_DATA, 8'h01);
    wr(`ADDR_P0_DIR, 8'hFE);
    wr(`ADDR_P0_PULL, 8'h04);
    step(1);
    cmp(8'(portZeroOe_q), 8'h01);
    cmp(8'(portZeroPullup_q), 8'h04);
    rd(`ADDR_P0_DATA, 8'h07);
    // A bit operation writes the input level of bit 1 into its latch
    wr(`ADDR_P0_DATA, 8'h07);
    wr(`ADDR_P0_DIR, 8'hFC);
    step(1);
    cmp(8'(portZeroOut_q & portZeroOe_q), 8'h03);
  endtask
  task automatic s_lcd;
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 8'((i + 1) << 4) & 8'h30;
      wr(`ADDR_LCDMODE, m);
      step(1);
      cmp(8'(lcdPinsOwned_q), 8'(m != 8'h00));
      cmp(8'(portZeroOe_q), m != 8'h00 ? 8'h00 : 8'h03);
    end
  endtask
  task automatic s_port5;
    wr(`ADDR_P5_DIR, 8'h0F);
    wr(`ADDR_P5_PULL, 8'h04);
    wr(`ADDR_P5_DATA, 8'h30);
    step(1);
    cmp(portFiveOe_q, 8'hF0);
    cmp(portFivePullup_q, 8'h04);
    cmp(portFiveOut_q & 8'hF0, 8'h30);
    wr(`ADDR_ALTSEL, 8'h31);
    step(1);
    cmp({portFiveOut_q[1], serialThreeReceive_q}, 8'h02);
    cmp(8'(portFiveOe_q[1]), 8'h01);
    @(posedge ref_clk);
    serialThreeTransmit <= 1'b0;
    step(1);
    cmp(8'(portFiveOut_q[1]), 8'h00);
    wr(`ADDR_ALTSEL, 8'h32);
    step(1);
    cmp({timerInputFour_q, timerInputTwo_q}, 8'h01);
    wr(`ADDR_ALTSEL, 8'h34);
    step(1);
    cmp(portFiveOut_q, 8'h3C);
  endtask
  task automatic s_port2;
    wr(`ADDR_ADCFG, 8'h04);
    wr(`ADDR_P2_DATA, 8'h03);
    wr(`ADDR_P2_DIR, 8'hFC);
    step(1);
    cmp(analogSelect_q, 8'hF0);
    cmp(portTwoOe_q, 8'h03);
    cmp(portTwoOut_q & 8'h03, 8'h03);
    rd(`ADDR_P2_DATA, 8'h0F);
    wr(`ADDR_ADCFG, 8'h09);
    rd(`ADDR_ADCFG, 8'h08);
    step(1);
    cmp(analogSelect_q, 8'h00);
  endtask
  task automatic s_debug;
    wr(`ADDR_ALTSEL, 8'h00);
    wr(`ADDR_STATUS, 8'h03);
    step(2);
    cmp({portFourOe_q, portFourOut_q, debugDataIn_q}, 8'h1F);
    @(posedge ref_clk);
    debugActive <= 1'b1;
    debugDataOe <= 1'b1;
    step(3);
    cmp({portFourOut_q, debugDataIn_q}, 8'h04);
    @(posedge ref_clk);
    debugTwoLine <= 1'b1;
    step(3);
    cmp(8'(portFourOut_q[1]), 8'h00);
    @(posedge ref_clk);
    debugActive <= 1'b0;
    debugTwoLine <= 1'b0;
    flashWriteMode <= 1'b1;
    step(3);
    cmp(8'(portFourOut_q), 8'h02);
  endtask
  task automatic results;
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    s_reset;
    s_port0;
    s_lcd;
    s_port5;
    s_port2;
    s_debug;
    results;
  end
  // Cuts a hang short
  initial begin
    #100000;
    miscompares++;
    results;
  end
endmodule

// File: bench/port_select_chk.sv
`timescale 1ns/100ps
// ==========================
// Pin ownership and bus checks
module port_select_chk #(
  parameter P0_WIDTH = 3,
  parameter P2_WIDTH = 8
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [7:0] regAddr,
  input wire regRead,
  input wire [7:0] regRdata_q,
  input wire [P0_WIDTH-1:0] portZeroOe_q,
  input wire lcdPinsOwned_q,
  input wire [P2_WIDTH-1:0] portTwoOe_q,
  input wire [P2_WIDTH-1:0] analogSelect_q,
  input wire debugActive,
  input wire debugTwoLine,
  input wire flashWriteMode,
  input wire debugDataOut,
  input wire debugDataOe,
  input wire debugClockOut,
  input wire [1:0] portFourOut_q,
  input wire [1:0] portFourOe_q,
  input wire debugDataIn_q
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  chk_lcd_no_drive: assert property (
    lcdPinsOwned_q |-> portZeroOe_q == '0)
    else $error("port zero driven in LCD use");
  chk_analog_no_drive: assert property (
    (analogSelect_q & portTwoOe_q) == '0)
    else $error("analog pin driven");
  chk_unmapped_zero: assert property (
    regRead && regAddr > 8'h0B |=> regRdata_q == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (!regRead |=> $stable(regRdata_q))
    else $error("read data moved without read");
  chk_clock_pin_owned: assert property (
    debugActive && debugTwoLine |=> portFourOut_q[1] == $past(debugClockOut))
    else $error("debug clock pin not owned");
  chk_data_pin_owned: assert property (
    debugActive || flashWriteMode |=> portFourOe_q[0] == $past(debugDataOe)
    && portFourOut_q[0] == $past(debugDataOut))
    else $error("debug data pin not owned");
  chk_data_in_idle: assert property (
    !(debugActive || flashWriteMode) |=> debugDataIn_q == 1'b1)
    else $error("debug data seen while port");
  chk_reset_digital_in: assert property (
    $rose(reset_n) |-> portTwoOe_q == '0 && analogSelect_q == '0)
    else $error("port two not digital input");
endmodule

bind port_pin_function_select port_select_chk #(
  .P0_WIDTH(P0_WIDTH),
  .P2_WIDTH(P2_WIDTH)
) chk (.ref_clk, .reset_n, .regAddr, .regRead, .regRdata_q, .portZeroOe_q,
  .lcdPinsOwned_q, .portTwoOe_q, .analogSelect_q, .debugActive,
  .debugTwoLine, .flashWriteMode, .debugDataOut, .debugDataOe,
  .debugClockOut, .portFourOut_q, .portFourOe_q, .debugDataIn_q);

// File: verilog/port_bit_cell.v
`timescale 1ns/100ps
// One port pin: output latch, pad drive and read-back select.
module port_bit_cell (
  input wire ref_clk,
  input wire reset_n,
  input wire writeEn,
  input wire writeBit,
  input wire dirIn,
  input wire funcOwned,
  input wire padIn,
  output reg latch_q,
  output wire padOut,
  output wire padOe,
  output wire readBit
);
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= 1'b0;
    end else if (writeEn) begin
      latch_q <= writeBit;
    end
  end
  assign padOut = latch_q;
  // Only the selected function controls the pin
  assign padOe = ~dirIn & ~funcOwned;
  // Output pins read the latch, input pins the pin level
  assign readBit = dirIn ? padIn : latch_q;
endmodule

// File: verilog/port_pin_function_select.v
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "port_select_map.vh"
// How it works
// - Port zero direction set per bit
// - Port zero pull-ups enabled per bit
// - Port zero is GPIO only when LCD bits zero
// - Debug clock pin is port unless 2-line debug is active
// - Debug disabled: debug data pin is port
// - Debugging or programming: data pin is debug only
// - Port five direction set per bit
// - Port five pull-ups enabled per bit
// - Port five carries serial, timer, segment alternates
// - Port two has latches and per-bit direction
// - Digital input: digital and input; from bit 0
// - Digital output: digital and output drives latch
// - Analog: analog and input; from highest bit
// - Reset puts port two in digital input
// - Write updates latch; input pins read pin level, analog-selected pins read 0
// - Bit operation: read 8, modify, write 8
module port_pin_function_select #(
  parameter P0_WIDTH = 3,
  parameter P5_WIDTH = 8,
  parameter P2_WIDTH = 8
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata_q,
  input wire [P0_WIDTH-1:0] portZeroIn,
  output reg [P0_WIDTH-1:0] portZeroOut_q,
  output reg [P0_WIDTH-1:0] portZeroOe_q,
  output reg [P0_WIDTH-1:0] portZeroPullup_q,
  output reg lcdPinsOwned_q,
  input wire [P5_WIDTH-1:0] portFiveIn,
  output reg [P5_WIDTH-1:0] portFiveOut_q,
  output reg [P5_WIDTH-1:0] portFiveOe_q,
  output reg [P5_WIDTH-1:0] portFivePullup_q,
  input wire serialThreeTransmit,
  output reg serialThreeReceive_q,
  output reg timerInputTwo_q,
  output reg timerInputFour_q,
  input wire [P5_WIDTH-1:0] lcdSegmentOutput,
  input wire [P2_WIDTH-1:0] portTwoIn,
  output reg [P2_WIDTH-1:0] portTwoOut_q,
  output reg [P2_WIDTH-1:0] portTwoOe_q,
  output reg [P2_WIDTH-1:0] analogSelect_q,
  input wire debugEnableOptionBit,
  input wire debugActive,
  input wire debugTwoLine,
  input wire flashWriteMode,
  input wire debugDataOut,
  input wire debugDataOe,
  input wire debugClockOut,
  input wire [1:0] portFourIn,
  output reg [1:0] portFourOut_q,
  output reg [1:0] portFourOe_q,
  output reg debugDataIn_q,
  output reg debugDataSampled_q
);
  // ===================================================================
  // Control registers
  reg [7:0] portZeroDirectionReg_q;
  reg [7:0] portZeroPullupReg_q;
  reg [7:0] portFiveDirectionReg_q;
  reg [7:0] portFivePullupReg_q;
  reg [7:0] portTwoDirectionReg_q;
  reg [3:0] analogDigitalConfigReg_q;
  reg [7:0] lcdModeReg_q;
  reg [2:0] altSelect_q;
  reg [1:0] portFourDir_q;
  reg [1:0] portFourLatch_q;
  reg resetSeen_q;

  wire lcdOwned;
  wire debugDataOwned;
  wire debugClockOwned;
  wire [P2_WIDTH-1:0] analogMask;
  wire [P5_WIDTH-1:0] fiveAltMask;
  wire [P0_WIDTH-1:0] zeroLatch;
  wire [P0_WIDTH-1:0] zeroPadOut;
  wire [P0_WIDTH-1:0] zeroPadOe;
  wire [P0_WIDTH-1:0] zeroRead;
  wire [P5_WIDTH-1:0] fiveLatch;
  wire [P5_WIDTH-1:0] fivePadOut;
  wire [P5_WIDTH-1:0] fivePadOe;
  wire [P5_WIDTH-1:0] fiveRead;
  wire [P2_WIDTH-1:0] twoLatch;
  wire [P2_WIDTH-1:0] twoPadOut;
  wire [P2_WIDTH-1:0] twoPadOe;
  wire [P2_WIDTH-1:0] twoRead;
  wire [1:0] fourRead;
  reg [7:0] readMux;

  // LCD capacitor and supply use while either mode bit is set
  assign lcdOwned = lcdModeReg_q[`LCD_SEL_HI] | lcdModeReg_q[`LCD_SEL_LO];
  // Debug data pin is a port only in normal use with debug off
  assign debugDataOwned = debugActive | flashWriteMode;
  // Debug clock pin is taken only by the two-line debugger
  // In one-line mode the clock pin stays an ordinary port
  assign debugClockOwned = debugActive & debugTwoLine;

  // ===================================================================
  // Alternate and analog masks
  genvar gi;
  generate
    for (gi = 0; gi < P2_WIDTH; gi = gi + 1) begin : gAnalog
      // Digital pins fill from bit 0, analog from the top
      // A count equal to the port width leaves every pin digital
      assign analogMask[gi] = (gi >= analogDigitalConfigReg_q) &
        portTwoDirectionReg_q[gi];
    end
    for (gi = 0; gi < P5_WIDTH; gi = gi + 1) begin : gFiveAlt
      if (gi == 1) begin : gTx
        assign fiveAltMask[gi] = altSelect_q[`ALT_SERIAL] |
          altSelect_q[`ALT_SEGMENT];
      end else begin : gOther
        assign fiveAltMask[gi] = altSelect_q[`ALT_SEGMENT];
      end
    end
    // =================================================================
    // Pin cells
    for (gi = 0; gi < P0_WIDTH; gi = gi + 1) begin : gZero
      port_bit_cell uCell (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .writeEn(regWrite && regAddr == `ADDR_P0_DATA),
        .writeBit(regWdata[gi]),
        .dirIn(portZeroDirectionReg_q[gi]),
        .funcOwned(lcdOwned),
        .padIn(portZeroIn[gi]),
        .latch_q(zeroLatch[gi]),
        .padOut(zeroPadOut[gi]),
        .padOe(zeroPadOe[gi]),
        .readBit(zeroRead[gi])
      );
    end
    for (gi = 0; gi < P5_WIDTH; gi = gi + 1) begin : gFive
      port_bit_cell uCell (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .writeEn(regWrite && regAddr == `ADDR_P5_DATA),
        .writeBit(regWdata[gi]),
        .dirIn(portFiveDirectionReg_q[gi]),
        .funcOwned(fiveAltMask[gi]),
        .padIn(portFiveIn[gi]),
        .latch_q(fiveLatch[gi]),
        .padOut(fivePadOut[gi]),
        .padOe(fivePadOe[gi]),
        .readBit(fiveRead[gi])
      );
    end
    for (gi = 0; gi < P2_WIDTH; gi = gi + 1) begin : gTwo
      port_bit_cell uCell (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .writeEn(regWrite && regAddr == `ADDR_P2_DATA),
        .writeBit(regWdata[gi]),
        .dirIn(portTwoDirectionReg_q[gi]),
        .funcOwned(analogMask[gi]),
        .padIn(portTwoIn[gi]),
        .latch_q(twoLatch[gi]),
        .padOut(twoPadOut[gi]),
        .padOe(twoPadOe[gi]),
        .readBit(twoRead[gi])
      );
    end
  endgenerate

  // Port four reads the pin level when input, the latch when output
  assign fourRead = (portFourDir_q & portFourIn) |
    (~portFourDir_q & portFourLatch_q);

  // ===================================================================
  // Register writes
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      portZeroDirectionReg_q <= `DIR_RESET;
      portZeroPullupReg_q <= `ZERO_RESET;
      portFiveDirectionReg_q <= `DIR_RESET;
      portFivePullupReg_q <= `ZERO_RESET;
      portTwoDirectionReg_q <= `DIR_RESET;
      analogDigitalConfigReg_q <= `ADCFG_RESET;
      lcdModeReg_q <= `ZERO_RESET;
      altSelect_q <= 3'h0;
      portFourDir_q <= 2'h3;
      portFourLatch_q <= 2'h0;
    end else if (regWrite) begin
      // Whole-byte writes only: a bit operation is read, modify, write
      // of all eight bits, so input levels may land in latches
      if (regAddr == `ADDR_P0_DIR) begin
        portZeroDirectionReg_q <= regWdata;
      end else if (regAddr == `ADDR_P0_PULL) begin
        portZeroPullupReg_q <= regWdata;
      end else if (regAddr == `ADDR_P5_DIR) begin
        portFiveDirectionReg_q <= regWdata;
      end else if (regAddr == `ADDR_P5_PULL) begin
        portFivePullupReg_q <= regWdata;
      end else if (regAddr == `ADDR_P2_DIR) begin
        portTwoDirectionReg_q <= regWdata;
      end else if (regAddr == `ADDR_ADCFG) begin
        // Counts above the port width clamp to all digital
        if (regWdata > `ADCFG_MAX) begin
          analogDigitalConfigReg_q <= `ADCFG_RESET;
        end else begin
          analogDigitalConfigReg_q <= regWdata[3:0];
        end
      end else if (regAddr == `ADDR_LCDMODE) begin
        lcdModeReg_q <= regWdata;
      end else if (regAddr == `ADDR_ALTSEL) begin
        altSelect_q <= regWdata[2:0];
        portFourDir_q <= regWdata[5:4];
      end else if (regAddr == `ADDR_STATUS) begin
        portFourLatch_q <= regWdata[1:0];
      end
    end
  end

  // ===================================================================
  // Read port: data one cycle after the strobe, zero when unmapped
  always @* begin
    readMux = 8'h00;
    if (regAddr == `ADDR_P0_DATA) begin
      readMux[P0_WIDTH-1:0] = zeroRead;
    end else if (regAddr == `ADDR_P0_DIR) begin
      readMux = portZeroDirectionReg_q;
    end else if (regAddr == `ADDR_P0_PULL) begin
      readMux = portZeroPullupReg_q;
    end else if (regAddr == `ADDR_P5_DATA) begin
      readMux[P5_WIDTH-1:0] = fiveRead;
    end else if (regAddr == `ADDR_P5_DIR) begin
      readMux = portFiveDirectionReg_q;
    end else if (regAddr == `ADDR_P5_PULL) begin
      readMux = portFivePullupReg_q;
    end else if (regAddr == `ADDR_P2_DATA) begin
      readMux[P2_WIDTH-1:0] = twoRead & ~analogMask;
    end else if (regAddr == `ADDR_P2_DIR) begin
      readMux = portTwoDirectionReg_q;
    end else if (regAddr == `ADDR_ADCFG) begin
      readMux[3:0] = analogDigitalConfigReg_q;
    end else if (regAddr == `ADDR_LCDMODE) begin
      readMux = lcdModeReg_q;
    end else if (regAddr == `ADDR_ALTSEL) begin
      readMux = {2'h0, portFourDir_q, 1'b0, altSelect_q};
    end else if (regAddr == `ADDR_STATUS) begin
      readMux = {debugDataOwned, debugClockOwned, lcdOwned,
        debugDataSampled_q, 2'h0, fourRead};
    end
  end

  // ===================================================================
  // Registered pin drive
  // Pins lag the registers by one cycle: glitch-free drive is worth
  // the extra clock of latency on a slow software-driven port
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata_q <= 8'h00;
      portZeroOut_q <= {P0_WIDTH{1'b0}};
      portZeroOe_q <= {P0_WIDTH{1'b0}};
      portZeroPullup_q <= {P0_WIDTH{1'b0}};
      lcdPinsOwned_q <= 1'b0;
      portFiveOut_q <= {P5_WIDTH{1'b0}};
      portFiveOe_q <= {P5_WIDTH{1'b0}};
      portFivePullup_q <= {P5_WIDTH{1'b0}};
      serialThreeReceive_q <= 1'b1;
      timerInputTwo_q <= 1'b0;
      timerInputFour_q <= 1'b0;
      portTwoOut_q <= {P2_WIDTH{1'b0}};
      portTwoOe_q <= {P2_WIDTH{1'b0}};
      analogSelect_q <= {P2_WIDTH{1'b0}};
      portFourOut_q <= 2'h0;
      portFourOe_q <= 2'h0;
      debugDataIn_q <= 1'b1;
    end else begin
      if (regRead) begin
        regRdata_q <= readMux;
      end
      portZeroOut_q <= zeroPadOut;
      portZeroOe_q <= zeroPadOe;
      // Pull-ups only on input pins still in port use
      portZeroPullup_q <= portZeroPullupReg_q[P0_WIDTH-1:0] &
        portZeroDirectionReg_q[P0_WIDTH-1:0] & {P0_WIDTH{~lcdOwned}};
      lcdPinsOwned_q <= lcdOwned;
      portFivePullup_q <= portFivePullupReg_q[P5_WIDTH-1:0] &
        portFiveDirectionReg_q[P5_WIDTH-1:0] & ~fiveAltMask;
      // Segment mode takes every port-five pin; a serial selection then
      // keeps only receive from pin 0, and pin 1 carries segment data, not transmit
      if (altSelect_q[`ALT_SEGMENT]) begin
        portFiveOut_q <= lcdSegmentOutput;
        portFiveOe_q <= {P5_WIDTH{1'b1}};
      end else begin
        portFiveOut_q <= fivePadOut;
        portFiveOe_q <= fivePadOe;
        if (altSelect_q[`ALT_SERIAL]) begin
          portFiveOut_q[1] <= serialThreeTransmit;
          portFiveOe_q[1] <= 1'b1;
        end
      end
      serialThreeReceive_q <= altSelect_q[`ALT_SERIAL] ?
        portFiveIn[0] : 1'b1;
      timerInputTwo_q <= altSelect_q[`ALT_TIMER] & portFiveIn[2];
      timerInputFour_q <= altSelect_q[`ALT_TIMER] & portFiveIn[3];
      portTwoOut_q <= twoPadOut;
      portTwoOe_q <= twoPadOe;
      analogSelect_q <= analogMask;
      // Debug data pin, then debug clock pin
      if (debugDataOwned) begin
        portFourOut_q[0] <= debugDataOut;
        portFourOe_q[0] <= debugDataOe;
      end else begin
        portFourOut_q[0] <= portFourLatch_q[0];
        portFourOe_q[0] <= ~portFourDir_q[0];
      end
      if (debugClockOwned) begin
        portFourOut_q[1] <= debugClockOut;
        portFourOe_q[1] <= 1'b1;
      end else begin
        portFourOut_q[1] <= portFourLatch_q[1];
        portFourOe_q[1] <= ~portFourDir_q[1];
      end
      debugDataIn_q <= debugDataOwned ? portFourIn[0] : 1'b1;
    end
  end

  // ===================================================================
  // Level of the debug data pin caught once after reset release;
  // with debug enabled the board must hold it high by then
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      resetSeen_q <= 1'b0;
      debugDataSampled_q <= 1'b0;
    end else if (!resetSeen_q) begin
      resetSeen_q <= 1'b1;
      debugDataSampled_q <= debugEnableOptionBit & portFourIn[0];
    end
  end
endmodule

// File: verilog/port_select_map.vh
`ifndef PORT_SELECT_MAP_VH
`define PORT_SELECT_MAP_VH
// =====================================================================
// Register addresses
`define ADDR_P0_DATA 8'h00
`define ADDR_P0_DIR 8'h01
`define ADDR_P0_PULL 8'h02
`define ADDR_P5_DATA 8'h03
`define ADDR_P5_DIR 8'h04
`define ADDR_P5_PULL 8'h05
`define ADDR_P2_DATA 8'h06
`define ADDR_P2_DIR 8'h07
`define ADDR_ADCFG 8'h08
`define ADDR_LCDMODE 8'h09
`define ADDR_ALTSEL 8'h0A
`define ADDR_STATUS 8'h0B
// =====================================================================
// Fields and reset values
`define LCD_SEL_HI 5
`define LCD_SEL_LO 4
`define ALT_SERIAL 0
`define ALT_TIMER 1
`define ALT_SEGMENT 2
`define DIR_RESET 8'hFF
`define ZERO_RESET 8'h00
// Count of digital pins; 8 means all digital
`define ADCFG_RESET 4'h8
// Largest digital-pin count that the config register accepts
`define ADCFG_MAX 8'h08
`endif
